/* rtl/io_cmd_regs.v */
`include "io_cmd_defs.vh"
`default_nettype none
module io_cmd_regs #(
  parameter PINS = 8,
  parameter DAC_W = 12,
  parameter CH_W = 3
) (
  input wire clk,
  input wire rst_n,
  input wire cmd_valid,
  input wire [15:0] cmd_word,
  input wire [PINS-1:0] pin_is_output,
  input wire [PINS-1:0] pin_out_level,
  input wire [CH_W-1:0] dac_rd_ch,
  output reg [PINS-1:0] pin_drive_type_q,
  output reg [PINS-1:0] pin_three_state_select_q,
  output reg [PINS-1:0] pin_o_q,
  output reg [PINS-1:0] pin_oe_n_q,
  output reg soft_reset_q,
  output reg dac_load_q,
  output reg [CH_W-1:0] dac_load_ch_q,
  output reg [DAC_W-1:0] dac_load_code_q,
  output wire [DAC_W-1:0] dac_rd_code
);
  wire is_dac;
  wire [PINS-1:0] pins;
  wire key_ok;
  wire live;
  wire wr_drive;
  wire wr_three_state;
  wire rst_hit;
  wire dac_wr;
  wire clr;
  reg [PINS-1:0] pad_oe_n_d;
  reg [PINS-1:0] pad_o_d;
  integer k;

  // write strobe for one register address code
  function reg_write;
    input valid;
    input [15:0] word;
    input [3:0] code;
    begin
      reg_write = valid && !word[`CMD_DAC_BIT] &&
        (word[`CMD_ADDR_HI:`CMD_ADDR_LO] == code);
    end
  endfunction

  // channel field of a dac write
  function [CH_W-1:0] dac_channel;
    input [15:0] word;
    begin
      dac_channel = word[`CMD_CH_HI:`CMD_CH_LO];
    end
  endfunction

  // code field of a dac write
  function [DAC_W-1:0] dac_code;
    input [15:0] word;
    begin
      dac_code = word[`CMD_DATA_HI:`CMD_DATA_LO];
    end
  endfunction

  // pad enable, low only while the pad is driven
  function pad_oe_n;
    input ts;
    input is_out;
    input od;
    input level;
    begin
      if (ts || !is_out) begin
        pad_oe_n = 1'b1;
      end else if (od) begin
        pad_oe_n = level;
      end else begin
        pad_oe_n = 1'b0;
      end
    end
  endfunction

  // pad value, only a push-pull pad shows the level
  function pad_o;
    input ts;
    input is_out;
    input od;
    input level;
    begin
      if (ts || !is_out || od) begin
        pad_o = 1'b0;
      end else begin
        pad_o = level;
      end
    end
  endfunction

  assign is_dac = cmd_word[`CMD_DAC_BIT];
  assign pins = cmd_word[`CMD_PIN_HI:`CMD_PIN_LO];
  assign key_ok = (cmd_word[`CMD_KEY_HI:`CMD_KEY_LO] == `SOFTWARE_RESET_KEY_KEY);
  // commands in the keyed reset cycle are dropped
  assign live = !soft_reset_q;
  assign wr_drive = live && reg_write(cmd_valid, cmd_word, `ADDR_DRIVE_TYPE);
  assign wr_three_state = live && reg_write(cmd_valid, cmd_word, `ADDR_THREE_STATE);
  assign rst_hit = live && key_ok && reg_write(cmd_valid, cmd_word, `ADDR_SOFTWARE_RESET_KEY);
  assign dac_wr = live && cmd_valid && is_dac;
  assign clr = !rst_n || soft_reset_q;

  always @* begin
    pad_oe_n_d = {PINS{1'b1}};
    pad_o_d = {PINS{1'b0}};
    for (k = 0; k < PINS; k = k + 1) begin
      pad_oe_n_d[k] = pad_oe_n(pin_three_state_select_q[k], pin_is_output[k],
        pin_drive_type_q[k], pin_out_level[k]);
      pad_o_d[k] = pad_o(pin_three_state_select_q[k], pin_is_output[k],
        pin_drive_type_q[k], pin_out_level[k]);
    end
  end

  // drive-type register
  always @(posedge clk) begin
    if (clr) begin
      pin_drive_type_q <= `PIN_RESET;
    end else if (wr_drive) begin
      pin_drive_type_q <= pins;
    end
  end

  // three-state register
  always @(posedge clk) begin
    if (clr) begin
      pin_three_state_select_q <= `PIN_RESET;
    end else if (wr_three_state) begin
      pin_three_state_select_q <= pins;
    end
  end

  // last dac write and its strobe
  always @(posedge clk) begin
    if (clr) begin
      dac_load_q <= 1'b0;
      dac_load_ch_q <= {CH_W{1'b0}};
      dac_load_code_q <= `DAC_RESET;
    end else begin
      dac_load_q <= dac_wr;
      if (dac_wr) begin
        dac_load_ch_q <= dac_channel(cmd_word);
        dac_load_code_q <= dac_code(cmd_word);
      end
    end
  end

  // pad driver registers
  always @(posedge clk) begin
    if (clr) begin
      pin_o_q <= `PIN_RESET;
      pin_oe_n_q <= {PINS{1'b1}};
    end else begin
      pin_o_q <= pad_o_d;
      pin_oe_n_q <= pad_oe_n_d;
    end
  end

  // wrong key leaves everything as is
  always @(posedge clk) begin
    if (!rst_n) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= rst_hit;
    end
  end

  dac_code_mem #(.DW(DAC_W), .AW(CH_W)) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .clr(soft_reset_q),
    .we(dac_wr),
    .waddr(dac_channel(cmd_word)),
    .wdata(dac_code(cmd_word)),
    .raddr(dac_rd_ch),
    .rdata(dac_rd_code)
  );
endmodule // io_cmd_regs
`default_nettype wire

/* rtl/io_cmd_defs.vh */
`ifndef IO_CMD_DEFS_VH
`define IO_CMD_DEFS_VH
`define CMD_W 16
`define CMD_DAC_BIT 15
`define CMD_ADDR_HI 14
`define CMD_ADDR_LO 11
`define CMD_CH_HI 14
`define CMD_CH_LO 12
`define CMD_DATA_HI 11
`define CMD_DATA_LO 0
`define CMD_KEY_HI 10
`define CMD_KEY_LO 0
`define CMD_PIN_HI 7
`define CMD_PIN_LO 0
`define ADDR_DRIVE_TYPE 4'hc
`define ADDR_THREE_STATE 4'hd
`define ADDR_SOFTWARE_RESET_KEY 4'hf
`define SOFTWARE_RESET_KEY_KEY 11'h5ac
`define PIN_RESET 8'h00
`define DAC_RESET 12'h000
`endif

/* rtl/dac_code_mem.v */
`default_nettype none
module dac_code_mem #(
  parameter DW = 12,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire clr,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer i;
  // clear on hard reset or keyed reset
  always @(posedge clk) begin
    if (!rst_n || clr) begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
        mem[i] <= {DW{1'b0}};
      end
      rdata <= {DW{1'b0}};
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // dac_code_mem
`default_nettype wire

/* dv/io_cmd_regs_sva.sv */
`default_nettype none
module io_cmd_regs_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic soft_reset_q,
  input wire logic dac_load_q,
  input wire logic [15:0] cmd_word,
  input wire logic [7:0] pin_drive_type_q,
  input wire logic [7:0] pin_three_state_select_q,
  input wire logic [2:0] dac_load_ch_q,
  input wire logic [11:0] dac_load_code_q
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire logic go = cmd_valid && !soft_reset_q;
  wire logic [15:0] pins = {pin_drive_type_q, pin_three_state_select_q};
  sequence key_cmd;
    go && cmd_word == 16'h7dac;
  endsequence
  AST_DRV: assert property (go && cmd_word[15:11] == 5'h0c
    |=> pin_drive_type_q == $past(cmd_word[7:0])) else $error("drive");
  AST_TS: assert property (go && cmd_word[15:11] == 5'h0d
    |=> pin_three_state_select_q == $past(cmd_word[7:0])) else $error("ts");
  AST_DAC: assert property (go && cmd_word[15] |=> dac_load_q &&
    {dac_load_ch_q, dac_load_code_q} == $past(cmd_word[14:0])) else $error("dac");
  AST_KEY: assert property (key_cmd |=> soft_reset_q ##1 pins == 0) else $error("key");
  AST_BAD: assert property (go && cmd_word[15:11] == 5'h0f && cmd_word[10:0] != 11'h5ac
    |=> !soft_reset_q && $stable(pins)) else $error("bad key");
  AST_RST: assert property (disable iff (1'b0) !rst_n |=> pins == 0) else $error("rst");
endmodule // io_cmd_regs_sva
bind io_cmd_regs io_cmd_regs_sva u_io_cmd_regs_sva (.*);
`default_nettype wire

/* dv/cmd_host.sv */
`default_nettype none
module cmd_host (
  input wire logic clk,
  output var logic cmd_valid = 1'b0,
  output var logic [15:0] cmd_word = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic send(input logic [15:0] w);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_word = w;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_word = ~w;
  endtask
endmodule // cmd_host
`default_nettype wire

/* dv/test_io_cmd_regs.sv */
`default_nettype none
module test_io_cmd_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] pin_is_output = 8'hff;
  logic [7:0] pin_out_level = 8'hff;
  logic [2:0] dac_rd_ch = 3'h5;
  wire logic cmd_valid, soft_reset_q, dac_load_q;
  wire logic [15:0] cmd_word;
  wire logic [7:0] pin_drive_type_q, pin_three_state_select_q, pin_o_q, pin_oe_n_q;
  wire logic [2:0] dac_load_ch_q;
  wire logic [11:0] dac_load_code_q, dac_rd_code;
  int mismatches = 0;
  int check_count = 0;
  io_cmd_regs u_io_cmd_regs (.*);
  cmd_host u_cmd_host (.*);
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_pins;
    chk({pin_drive_type_q, pin_oe_n_q}, 16'h00ff);
    u_cmd_host.send(16'h60a5);
    u_cmd_host.send(16'h683c);
    @(negedge clk);
    chk({pin_three_state_select_q, pin_oe_n_q}, 16'h3cbd);
    chk(pin_o_q, 8'h42);
    pin_out_level = 8'h00;
    @(negedge clk);
    chk({pin_oe_n_q, pin_o_q}, 16'h3c00);
    pin_is_output = 8'h0f;
    pin_out_level = 8'hff;
    @(negedge clk);
    chk({pin_oe_n_q, pin_o_q}, 16'hfd02);
    pin_is_output = 8'hff;
    $display("pins done");
  endtask
  task automatic t_dac;
    for (int c = 0; c < 8; c++) begin
      u_cmd_host.send({1'b1, c[2:0], 12'hf00 | c[11:0]});
      chk({dac_load_q, dac_load_ch_q, dac_load_code_q}, 16'(16'h8f00 | c * 16'h1001));
    end
    chk(dac_rd_code, 12'hf05);
    $display("dac done");
  endtask
  task automatic t_key;
    u_cmd_host.send(16'h7dad);
    chk({soft_reset_q, pin_drive_type_q}, 16'h00a5);
    u_cmd_host.send(16'h7dac);
    chk(soft_reset_q, 1'b1);
    repeat (2) @(negedge clk);
    chk({pin_drive_type_q, pin_three_state_select_q}, 16'h0000);
    chk(dac_rd_code, 12'h000);
    chk(soft_reset_q, 1'b0);
    $display("key done");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_pins();
    t_dac();
    t_key();
    end_sim();
  end
endmodule // test_io_cmd_regs
`default_nettype wire
